// file: src/usb_pkg.sv
// constants for the uart shadow buffer window block
// assumes a 32-bit avalon-mm byte address bus and one 250 MHz clock
package usb_pkg;

  // ******************************************************
  // address map
  // ******************************************************
  localparam logic [31:0] ADDR_SHADOW_2   = 32'h50001038;
  localparam logic [31:0] ADDR_SHADOW_3   = 32'h5000103C;
  localparam logic [31:0] SHADOW_STRIDE   = 32'h00000004;
  localparam logic [31:0] ADDR_SHADOW_0   = ADDR_SHADOW_2 - 32'h00000008;
  localparam logic [31:0] ADDR_SHADOW_END = ADDR_SHADOW_0 + 32'h00000040;
  localparam logic [31:0] ADDR_CONTROL    = 32'h50001080;
  localparam logic [31:0] ADDR_LINE_STAT  = 32'h50001084;
  localparam logic [31:0] ADDR_IRQ_STAT   = 32'h50001088;
  localparam logic [31:0] ADDR_IRQ_MASK   = 32'h5000108C;
  localparam logic [31:0] ADDR_WORD_MASK  = 32'h00000003;

  // ******************************************************
  // field positions
  // ******************************************************
  localparam int          CTRL_FIFO_EN_BIT = 0;
  localparam int          CTRL_IR_MODE_BIT = 1;
  localparam int          LSR_DR_BIT       = 0;
  localparam int          LSR_TRANSMIT_HOLDING_EMPTY_FLAG_BIT     = 5;
  localparam int          BYTE_W           = 8;
  localparam int          NUM_EVENTS       = 4;
  localparam int          EV_RX_OVERRUN    = 0;
  localparam int          EV_RX_ARRIVED    = 1;
  localparam int          EV_TX_DROPPED    = 2;
  localparam int          EV_TX_EMPTY      = 3;

  // ******************************************************
  // reset values
  // ******************************************************
  localparam logic [1:0]  CONTROL_RESET    = 2'h0;
  localparam logic [3:0]  IRQ_MASK_RESET   = 4'h0;
  localparam logic [31:0] READ_ZERO        = 32'h00000000;

  // bus answer state
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } usb_bus_state_t;

endpackage

// file: src/usb_shadow_buffer.sv
// uart shadow window onto the receive buffer and transmit holding register
// assumes byte-level serial and infrared serdes outside, synchronous to core_clk
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ns

// Functional notes
// - sixteen 32-bit aliases; read gives receive byte, write loads transmit holding
// - infrared mode uses infrared input and output, else serial input and output
// - received byte is valid only while data ready flag is set
// - fifos off: unread byte replaced by next arrival, overrun signalled
// - fifos on: shadow read returns head of receive fifo
// - receive fifo full: keep contents, drop incoming byte, signal overrun
// - fifos off: second write before transmit empty overwrites pending byte
// - fifos on: accept bytes up to fifo depth, default sixteen
// - write while transmit fifo full is dropped, contents unchanged
module usb_shadow_buffer #(
  parameter int DEPTH = 16
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [31:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [7:0]  serial_rx_byte,
  input  wire logic        serial_rx_valid,
  input  wire logic [7:0]  ir_rx_byte,
  input  wire logic        ir_rx_valid,
  output logic      [7:0]  serial_tx_byte,
  output logic             serial_tx_valid,
  input  wire logic        serial_tx_ready,
  output logic      [7:0]  ir_tx_byte,
  output logic             ir_tx_valid,
  input  wire logic        ir_tx_ready,
  output logic             data_ready_flag,
  output logic             transmit_holding_empty_flag,
  output logic             irq
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] ONE_C  = CW'(1);
  localparam logic [CW-1:0] FULL_C = CW'(DEPTH);
  localparam logic [PW-1:0] ONE_P  = PW'(1);
  localparam logic [PW-1:0] LAST_P = PW'(DEPTH - 1);

  // ******************************************************
  // decode helpers
  // ******************************************************
  // every word of the window aliases the same byte so bursts may walk through it
  function automatic logic is_shadow(input logic [31:0] a);
    is_shadow = (a >= usb_pkg::ADDR_SHADOW_0) && (a < usb_pkg::ADDR_SHADOW_END)
                && ((a & usb_pkg::ADDR_WORD_MASK) == usb_pkg::READ_ZERO);
  endfunction

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == LAST_P) ? '0 : p + ONE_P;
  endfunction

  usb_pkg::usb_bus_state_t bus_state_reg;
  logic [31:0]             readdata_reg;
  logic [1:0]              control_reg;
  logic [3:0]              irq_mask_reg;
  logic [3:0]              irq_stat_reg;
  logic [3:0]              events;
  logic                    fifo_en;
  logic                    ir_mode;
  logic                    fifo_en_d_reg;
  logic                    fifo_flush;
  logic                    bus_done;
  logic                    rd_take;
  logic                    wr_done;
  logic                    shadow_pop;
  logic                    shadow_push;
  logic [7:0]              rx_mem [DEPTH];
  logic [PW-1:0]           rx_wr_reg;
  logic [PW-1:0]           rx_rd_reg;
  logic [CW-1:0]           rx_cnt_reg;
  logic [7:0]              rx_in_byte;
  logic                    rx_in_valid;
  logic                    rx_full;
  logic                    rx_pop;
  logic                    rx_overwrite;
  logic                    rx_store;
  logic [7:0]              tx_mem [DEPTH];
  logic [PW-1:0]           tx_wr_reg;
  logic [PW-1:0]           tx_rd_reg;
  logic [CW-1:0]           tx_cnt_reg;
  logic                    tx_full;
  logic                    tx_pop;
  logic                    tx_overwrite;
  logic                    tx_store;
  logic                    tx_ready_sel;
  logic                    transmit_holding_empty_flag_d_reg;

  assign fifo_en    = control_reg[usb_pkg::CTRL_FIFO_EN_BIT];
  assign ir_mode    = control_reg[usb_pkg::CTRL_IR_MODE_BIT];
  // switching the fifo mode empties both paths so no stale pointer survives
  assign fifo_flush = fifo_en != fifo_en_d_reg;

  // ******************************************************
  // avalon slave: one wait state, then the answer
  // ******************************************************
  assign avs_waitrequest = (avs_read || avs_write) && (bus_state_reg == usb_pkg::BUS_IDLE);
  assign bus_done        = bus_state_reg == usb_pkg::BUS_ACK;
  // a read pops on the edge that captures its data: popping one edge later would
  // throw away a byte that lands in the wait cycle
  assign rd_take         = avs_read && (bus_state_reg == usb_pkg::BUS_IDLE);
  assign wr_done         = bus_done && avs_write;
  assign shadow_pop      = rd_take && is_shadow(avs_address);
  assign shadow_push     = wr_done && is_shadow(avs_address) && avs_byteenable[0];
  assign avs_readdata    = readdata_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      bus_state_reg <= usb_pkg::BUS_IDLE;
    end else begin
      case (bus_state_reg)
        usb_pkg::BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state_reg <= usb_pkg::BUS_ACK;
          end
        end
        usb_pkg::BUS_ACK: bus_state_reg <= usb_pkg::BUS_IDLE;
        default:          bus_state_reg <= usb_pkg::BUS_IDLE;
      endcase
    end
  end

  // read data is captured at the edge that ends the wait state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      readdata_reg <= usb_pkg::READ_ZERO;
    end else if (rd_take) begin
      readdata_reg <= usb_pkg::READ_ZERO;
      if (is_shadow(avs_address)) begin
        // upper bytes stay zero
        readdata_reg[usb_pkg::BYTE_W-1:0] <= rx_mem[rx_rd_reg];
      end else begin
        case (avs_address)
          usb_pkg::ADDR_CONTROL:   readdata_reg[1:0] <= control_reg;
          usb_pkg::ADDR_LINE_STAT: begin
            readdata_reg[usb_pkg::LSR_DR_BIT]   <= data_ready_flag;
            readdata_reg[usb_pkg::LSR_TRANSMIT_HOLDING_EMPTY_FLAG_BIT] <= transmit_holding_empty_flag;
          end
          usb_pkg::ADDR_IRQ_STAT:  readdata_reg[3:0] <= irq_stat_reg;
          usb_pkg::ADDR_IRQ_MASK:  readdata_reg[3:0] <= irq_mask_reg;
          default:                 readdata_reg      <= usb_pkg::READ_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      control_reg   <= usb_pkg::CONTROL_RESET;
      irq_mask_reg  <= usb_pkg::IRQ_MASK_RESET;
      fifo_en_d_reg <= 1'b0;
    end else begin
      fifo_en_d_reg <= fifo_en;
      // only byte lane 0 is decoded; a write without it changes nothing
      if (wr_done && avs_byteenable[0]) begin
        if (avs_address == usb_pkg::ADDR_CONTROL) begin
          control_reg <= avs_writedata[1:0];
        end
        if (avs_address == usb_pkg::ADDR_IRQ_MASK) begin
          irq_mask_reg <= avs_writedata[3:0];
        end
      end
    end
  end

  // ******************************************************
  // receive path
  // ******************************************************
  assign rx_in_byte   = ir_mode ? ir_rx_byte  : serial_rx_byte;
  assign rx_in_valid  = ir_mode ? ir_rx_valid : serial_rx_valid;
  assign rx_full      = fifo_en ? (rx_cnt_reg == FULL_C) : (rx_cnt_reg == ONE_C);
  assign rx_pop       = shadow_pop && (rx_cnt_reg != '0);
  // holding mode: an unread byte is replaced; a byte read in the same edge is not
  assign rx_overwrite = rx_in_valid && rx_full && !fifo_en && !rx_pop;
  assign rx_store     = rx_in_valid && (!rx_full || rx_pop) && !fifo_flush;
  // an empty read still shows the stale head byte; only data ready tells it apart
  assign data_ready_flag = rx_cnt_reg != '0;

  always_ff @(posedge core_clk) begin
    if (rx_overwrite) begin
      rx_mem[rx_rd_reg] <= rx_in_byte;
    end else if (rx_store) begin
      rx_mem[rx_wr_reg] <= rx_in_byte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset || fifo_flush) begin
      rx_wr_reg  <= '0;
      rx_rd_reg  <= '0;
      rx_cnt_reg <= '0;
    end else begin
      if (rx_store && !rx_overwrite) begin
        rx_wr_reg <= fifo_en ? ptr_inc(rx_wr_reg) : rx_wr_reg;
      end
      if (rx_pop) begin
        rx_rd_reg <= fifo_en ? ptr_inc(rx_rd_reg) : rx_rd_reg;
      end
      if (rx_store && !rx_pop) begin
        rx_cnt_reg <= rx_cnt_reg + ONE_C;
      end else if (rx_pop && !rx_store) begin
        rx_cnt_reg <= rx_cnt_reg - ONE_C;
      end
    end
  end

  // ******************************************************
  // transmit path
  // ******************************************************
  // the idle line's ready is ignored so a far end on it cannot drain bytes
  assign tx_ready_sel  = ir_mode ? ir_tx_ready : serial_tx_ready;
  assign tx_pop        = (tx_cnt_reg != '0) && tx_ready_sel;
  assign tx_full       = fifo_en ? (tx_cnt_reg == FULL_C) : (tx_cnt_reg == ONE_C);
  // holding mode: a write before the byte leaves replaces it
  assign tx_overwrite  = shadow_push && tx_full && !fifo_en && !tx_pop;
  // fifo mode: a full fifo drops the write untouched
  assign tx_store      = shadow_push && (!tx_full || tx_pop) && !fifo_flush;
  assign transmit_holding_empty_flag = tx_cnt_reg == '0;

  // low byte only: bits above are ignored
  always_ff @(posedge core_clk) begin
    if (tx_overwrite) begin
      tx_mem[tx_rd_reg] <= avs_writedata[usb_pkg::BYTE_W-1:0];
    end else if (tx_store) begin
      tx_mem[tx_wr_reg] <= avs_writedata[usb_pkg::BYTE_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset || fifo_flush) begin
      tx_wr_reg  <= '0;
      tx_rd_reg  <= '0;
      tx_cnt_reg <= '0;
    end else begin
      if (tx_store && !tx_overwrite) begin
        tx_wr_reg <= fifo_en ? ptr_inc(tx_wr_reg) : tx_wr_reg;
      end
      if (tx_pop) begin
        tx_rd_reg <= fifo_en ? ptr_inc(tx_rd_reg) : tx_rd_reg;
      end
      if (tx_store && !tx_pop) begin
        tx_cnt_reg <= tx_cnt_reg + ONE_C;
      end else if (tx_pop && !tx_store) begin
        tx_cnt_reg <= tx_cnt_reg - ONE_C;
      end
    end
  end

  // head byte goes to whichever line the mode selects
  assign serial_tx_byte  = tx_mem[tx_rd_reg];
  assign ir_tx_byte      = tx_mem[tx_rd_reg];
  assign serial_tx_valid = !ir_mode && (tx_cnt_reg != '0);
  assign ir_tx_valid     = ir_mode && (tx_cnt_reg != '0);

  // ******************************************************
  // interrupts
  // ******************************************************
  // the delayed empty flag resets high like the flag itself, so reset makes no false edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      transmit_holding_empty_flag_d_reg <= 1'b1;
    end else begin
      transmit_holding_empty_flag_d_reg <= transmit_holding_empty_flag;
    end
  end

  // overrun comes from the replace path with fifos off and from a full fifo with them on
  assign events[usb_pkg::EV_RX_OVERRUN] = rx_overwrite || (rx_in_valid && rx_full
                                          && fifo_en && !rx_pop);
  assign events[usb_pkg::EV_RX_ARRIVED] = rx_in_valid;
  assign events[usb_pkg::EV_TX_DROPPED] = shadow_push && tx_full && fifo_en && !tx_pop;
  assign events[usb_pkg::EV_TX_EMPTY]   = transmit_holding_empty_flag && !transmit_holding_empty_flag_d_reg;

  // set beats a same-cycle write-one-to-clear
  for (genvar i = 0; i < usb_pkg::NUM_EVENTS; i++) begin : g_irq
    always_ff @(posedge core_clk) begin
      if (reset) begin
        irq_stat_reg[i] <= 1'b0;
      end else if (events[i]) begin
        irq_stat_reg[i] <= 1'b1;
      end else if (wr_done && avs_byteenable[0] && avs_writedata[i]
                   && (avs_address == usb_pkg::ADDR_IRQ_STAT)) begin
        irq_stat_reg[i] <= 1'b0;
      end
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule // usb_shadow_buffer

// file: verif/usb_shadow_properties.sv
// port assertions for the uart shadow window
// assumes usb_pkg is compiled first; bound into every usb_shadow_buffer
`timescale 1ns/1ns
module usb_shadow_props #(
  parameter int DEPTH = 16
) (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic [31:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        serial_rx_valid,
  input wire logic        ir_rx_valid,
  input wire logic [7:0]  serial_tx_byte,
  input wire logic        serial_tx_valid,
  input wire logic        serial_tx_ready,
  input wire logic        ir_tx_valid,
  input wire logic        data_ready_flag,
  input wire logic        transmit_holding_empty_flag
);
  // ****
  // properties
  // ****
  logic hit;
  logic wdone;
  assign hit   = avs_address >= usb_pkg::ADDR_SHADOW_0 && avs_address < usb_pkg::ADDR_SHADOW_END;
  assign wdone = avs_write && !avs_waitrequest;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_wait_first; $rose(avs_read || avs_write) |-> avs_waitrequest; endproperty
  property p_wait_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  property p_one_side; !(serial_tx_valid && ir_tx_valid); endproperty
  property p_dr_cause; $rose(data_ready_flag) |-> $past(serial_rx_valid || ir_rx_valid); endproperty
  // a write may overwrite or flush, so only quiet cycles must hold
  property p_tx_hold;
    serial_tx_valid && !serial_tx_ready && !wdone && !$past(wdone)
      |=> serial_tx_valid && $stable(serial_tx_byte);
  endproperty
  property p_upper; avs_read && !avs_waitrequest && hit |-> avs_readdata[15:8] == 8'h00; endproperty
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address[31:8] != 24'h500010 |-> avs_readdata == 32'h0;
  endproperty
  property p_fill; wdone && hit && avs_byteenable[0] |=> !transmit_holding_empty_flag; endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait state");
  a_wait_ans: assert property (p_wait_ans) else $error("late answer");
  a_one_side: assert property (p_one_side) else $error("both transmit sides");
  a_dr_cause: assert property (p_dr_cause) else $error("data ready without byte");
  a_tx_hold: assert property (p_tx_hold) else $error("transmit byte moved");
  a_upper: assert property (p_upper) else $error("upper byte not zero");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_fill: assert property (p_fill) else $error("write not held");
  c_write: cover property (wdone && hit);
  c_tx: cover property (serial_tx_valid && serial_tx_ready);
  c_ir: cover property (ir_tx_valid);
endmodule // usb_shadow_props

bind usb_shadow_buffer usb_shadow_props #(.DEPTH(DEPTH)) i_props (.*);

// file: verif/usb_far_end.sv
// far-end transceiver model taking transmit bytes from serial or infrared side
// stall comes from the bench, changed just after a clock edge
`timescale 1ns/1ns
module usb_far_end (
  input wire logic       core_clk,
  input wire logic       stall,
  input wire logic [7:0] serial_tx_byte,
  input wire logic       serial_tx_valid,
  output logic           serial_tx_ready,
  input wire logic [7:0] ir_tx_byte,
  input wire logic       ir_tx_valid,
  output logic           ir_tx_ready
);
  logic [7:0] got[$];
  int         ir_count = 0;
  assign serial_tx_ready = !stall;
  assign ir_tx_ready     = !stall;
  always @(posedge core_clk) begin
    if (serial_tx_valid && serial_tx_ready) begin
      got.push_back(serial_tx_byte);
    end
    if (ir_tx_valid && ir_tx_ready) begin
      got.push_back(ir_tx_byte);
      ir_count++;
    end
  end
endmodule // usb_far_end

// file: verif/testbench.sv
// self-checking bench for the uart shadow window
// assumes usb_pkg, the design, checker and far-end model are compiled first
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  localparam int          D  = 16;
  localparam logic [31:0] LS = usb_pkg::ADDR_LINE_STAT;
  localparam logic [31:0] IS = usb_pkg::ADDR_IRQ_STAT;
  logic        core_clk, reset, avs_read, avs_write, stall, avs_waitrequest, irq;
  logic [31:0] avs_address, avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable;
  logic [7:0]  serial_rx_byte, ir_rx_byte, serial_tx_byte, ir_tx_byte;
  logic        serial_rx_valid, ir_rx_valid, serial_tx_valid, serial_tx_ready;
  logic        ir_tx_valid, ir_tx_ready, data_ready_flag, transmit_holding_empty_flag;
  int          errors = 0;
  int          samples_checked = 0;
  usb_shadow_buffer #(.DEPTH(D)) i_usb_shadow_buffer (.core_clk, .reset, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .serial_rx_byte, .serial_rx_valid, .ir_rx_byte, .ir_rx_valid, .serial_tx_byte,
    .serial_tx_valid, .serial_tx_ready, .ir_tx_byte, .ir_tx_valid, .ir_tx_ready,
    .data_ready_flag, .transmit_holding_empty_flag, .irq);
  usb_far_end i_far (.core_clk, .stall, .serial_tx_byte, .serial_tx_valid, .serial_tx_ready,
    .ir_tx_byte, .ir_tx_valid, .ir_tx_ready);
  // ****
  // tasks
  // ****
  function automatic logic [31:0] sa(input int i);
    return usb_pkg::ADDR_SHADOW_0 + 32'(4 * i);
  endfunction
  // request raised after an edge and held until an edge samples waitrequest low;
  // read data is taken at that same edge, before the design updates anything
  task automatic bus(input logic wr, input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (avs_waitrequest !== 1'b0) begin
      errors++;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic rdc(input logic [31:0] a, e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // with iv set, the serial side strobes an inverted byte to catch wrong routing
  task automatic rx(input logic iv, input logic [7:0] b);
    @(posedge core_clk);
    serial_rx_valid <= 1'b1;
    ir_rx_valid     <= iv;
    serial_rx_byte  <= iv ? ~b : b;
    ir_rx_byte      <= b;
    @(posedge core_clk);
    serial_rx_valid <= 1'b0;
    ir_rx_valid     <= 1'b0;
    serial_rx_byte  <= ~b;
    ir_rx_byte      <= ~b;
  endtask
  task automatic chk_irq(input logic e);
    @(posedge core_clk);
    `CHK(irq, e)
  endtask
  task automatic wait_got(input int n);
    int k;
    k = 0;
    while (i_far.got.size() < n && k < 200) begin
      @(posedge core_clk);
      k++;
    end
    `CHK(i_far.got.size(), n)
  endtask
  task automatic wrap_up;
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    #20000;
    errors++;
    wrap_up;
  end
  initial begin
    {reset, stall} = 2'b11;
    {avs_read, avs_write, serial_rx_valid, ir_rx_valid} = 4'h0;
    {avs_address, avs_writedata, serial_rx_byte, ir_rx_byte} = 80'h0;
    avs_byteenable = 4'hF;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    rdc(LS, 32'h20);
    rdc(32'h50001090, 32'h0);
    rdc(32'h60000000, 32'h0);
    rx(1'b0, 8'hA5);
    @(posedge core_clk);
    `CHK(data_ready_flag, 1'b1)
    rdc(LS, 32'h21);
    rdc(usb_pkg::ADDR_SHADOW_2, 32'hA5);
    rx(1'b0, 8'h11);
    rx(1'b0, 8'h22);
    rdc(sa(15), 32'h22);
    rdc(IS, 32'h3);
    bus(1'b1, IS, 32'hF);
    bus(1'b1, sa(0), 32'h33);
    @(posedge core_clk);
    `CHK(transmit_holding_empty_flag, 1'b0)
    bus(1'b1, sa(5), 32'h7744);
    rdc(LS, 32'h0);
    stall <= 1'b0;
    wait_got(1);
    `CHK(i_far.got[0], 8'h44)
    rdc(IS, 32'h8);
    stall <= 1'b1;
    bus(1'b1, usb_pkg::ADDR_CONTROL, 32'h1);
    bus(1'b1, usb_pkg::ADDR_IRQ_MASK, 32'h4);
    for (int i = 0; i <= D; i++) bus(1'b1, sa(i % 16), 32'h40 + i);
    chk_irq(1'b1);
    stall <= 1'b0;
    wait_got(D + 1);
    for (int i = 0; i < D; i++) `CHK(i_far.got[i + 1], 8'h40 + i)
    bus(1'b1, IS, 32'hF);
    chk_irq(1'b0);
    for (int i = 0; i <= D; i++) rx(1'b0, 8'(8'h80 + i));
    for (int i = 0; i < D; i++) rdc(sa(15 - i), 32'h80 + i);
    rdc(LS, 32'h20);
    rdc(IS, 32'h3);
    avs_byteenable <= 4'hE;
    bus(1'b1, sa(1), 32'h99);
    avs_byteenable <= 4'hF;
    rdc(LS, 32'h20);
    bus(1'b1, usb_pkg::ADDR_CONTROL, 32'h3);
    rx(1'b1, 8'h5A);
    rdc(sa(3), 32'h5A);
    bus(1'b1, sa(7), 32'h6C);
    wait_got(D + 2);
    `CHK(i_far.ir_count, 1)
    `CHK(i_far.got[D + 1], 8'h6C)
    wrap_up;
  end
endmodule // testbench
